// ### shared/gdio_params.svh
// Offsets, field positions, reset values and timing counts for the digital I/O port
`ifndef GDIO_PARAMS_SVH
`define GDIO_PARAMS_SVH
`define GDIO_OFF_INPUT 12'h000
`define GDIO_OFF_DIR 12'h004
`define GDIO_OFF_OUT 12'h008
`define GDIO_OFF_PULLUP 12'h00c
`define GDIO_OFF_PORT_CONTROL_REG 12'h010
`define GDIO_OFF_MCU_CONTROL_REG 12'h014
`define GDIO_OFF_SLEEP 12'h018
`define GDIO_OFF_EXTINT 12'h01c
`define GDIO_OFF_EXTFLAG 12'h020
`define GDIO_BIT_BBM 0
`define GDIO_BIT_PUD 0
`define GDIO_BIT_SLEEP 0
`define GDIO_RST_REG 8'h00
`define GDIO_BBM_HOLD_CYC 1
`endif

// ### shared/gdio_pkg.sv
// Types for the digital I/O port
package gdio_pkg;
  typedef enum logic [1:0] {
    GDIO_SLP_AWAKE = 2'b00,
    GDIO_SLP_DEEP = 2'b01,
    GDIO_SLP_WAKE = 2'b10
  } gdio_sleep_t;
endpackage

// ### logic/gdio_port.sv
// General-purpose digital I/O port with APB register access
`timescale 1ns/1ps
`include "gdio_params.svh"
// What this block does
// - Input sample register is read-only; output and direction registers read/write.
// - Writing one to an input register bit inverts the output value bit.
// - Global pull-up disable turns off every pull-up.
// - Direction bit one makes an output, zero an input.
// - Input pin is hi-Z, or pulled up when pull-up enable set.
// - Output pin drives output value; pull-up added when enabled.
// - Reset tri-states all pins asynchronously, without clock.
// - Break-before-make holds pin tri-stated one cycle on input-to-output change.
// - Break-before-make applies port-wide, enabled by port control bit.
// - No tri-state interval on output-to-input change.
// - Pin passes falling-edge latch then rising-edge register into input bit.
// - External transition reaches input bit after half to one-and-half periods.
// - Software-driven level reaches input bit one period after the write.
// - Deep sleep clamps digital input path to ground.
// - Pins with external interrupt enabled are not clamped.
// - High level on disabled interrupt pin sets its flag on wake.
// - Alternate function on some pins leaves the others unaffected.
// - Pull-ups stay disconnected while reset is active.
module gdio_port import gdio_pkg::*; #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Pads
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe_out,
  output logic [WIDTH-1:0] pad_pullup_out,
  // Alternate function claim per pin
  input wire logic [WIDTH-1:0] alt_claim_in,
  output logic [WIDTH-1:0] input_clamp_out
);
  logic [WIDTH-1:0] port_direction_reg;
  logic [WIDTH-1:0] port_output_value_reg;
  logic [WIDTH-1:0] pullup_enable_reg;
  logic [WIDTH-1:0] port_input_sample_reg;
  logic [WIDTH-1:0] sync_latch;
  logic [WIDTH-1:0] dir_prev;
  logic [WIDTH-1:0] ext_int_enable;
  logic [WIDTH-1:0] ext_int_flag;
  logic break_before_make_enable;
  logic global_pullup_disable;
  logic sleep_request;
  gdio_sleep_t sleep_state;
  gdio_sleep_t next_sleep_state;

  // Address decode
  wire wr_phase = psel_in & penable_in & pwrite_in;
  wire hit_input = paddr_in == `GDIO_OFF_INPUT;
  wire hit_dir = paddr_in == `GDIO_OFF_DIR;
  wire hit_out = paddr_in == `GDIO_OFF_OUT;
  wire hit_pu = paddr_in == `GDIO_OFF_PULLUP;
  wire hit_pcr = paddr_in == `GDIO_OFF_PORT_CONTROL_REG;
  wire hit_mcu = paddr_in == `GDIO_OFF_MCU_CONTROL_REG;
  wire hit_slp = paddr_in == `GDIO_OFF_SLEEP;
  wire hit_eie = paddr_in == `GDIO_OFF_EXTINT;
  wire hit_efl = paddr_in == `GDIO_OFF_EXTFLAG;
  wire hit_any = hit_input | hit_dir | hit_out | hit_pu | hit_pcr | hit_mcu | hit_slp | hit_eie | hit_efl;
  wire [WIDTH-1:0] wdata = pwdata_in[WIDTH-1:0];

  wire [WIDTH-1:0] next_out_value = (wr_phase & hit_input) ? (port_output_value_reg ^ wdata) :
                                    (wr_phase & hit_out) ? wdata : port_output_value_reg;

  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit_any;

  // Read mux, input sample register read-only
  wire [WIDTH-1:0] rd_port = hit_input ? port_input_sample_reg :
                             hit_dir ? port_direction_reg :
                             hit_out ? port_output_value_reg :
                             hit_pu ? pullup_enable_reg :
                             hit_eie ? ext_int_enable :
                             hit_efl ? ext_int_flag : '0;
  wire [31:0] rd_word = {{(32-WIDTH){1'b0}}, rd_port} |
                        {31'h0, (hit_pcr & break_before_make_enable) | (hit_mcu & global_pullup_disable) |
                                (hit_slp & sleep_request)};

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      port_direction_reg <= '0;
      port_output_value_reg <= '0;
      pullup_enable_reg <= '0;
      break_before_make_enable <= 1'b0;
      global_pullup_disable <= 1'b0;
      sleep_request <= 1'b0;
      ext_int_enable <= '0;
      dir_prev <= '0;
      prdata_out <= 32'h0;
    end else begin
      port_output_value_reg <= next_out_value;
      if (wr_phase & hit_dir) port_direction_reg <= wdata;
      if (wr_phase & hit_pu) pullup_enable_reg <= wdata;
      if (wr_phase & hit_pcr) break_before_make_enable <= pwdata_in[`GDIO_BIT_BBM];
      if (wr_phase & hit_mcu) global_pullup_disable <= pwdata_in[`GDIO_BIT_PUD];
      if (wr_phase & hit_slp) sleep_request <= pwdata_in[`GDIO_BIT_SLEEP];
      if (wr_phase & hit_eie) ext_int_enable <= wdata;
      dir_prev <= port_direction_reg;
      if (psel_in & ~penable_in & ~pwrite_in) prdata_out <= rd_word;
    end
  end

  // One-cycle break on rising direction, port-wide enable
  wire [WIDTH-1:0] bbm_hold = {WIDTH{break_before_make_enable}} & port_direction_reg & ~dir_prev;
  assign pad_oe_out = {WIDTH{rstn_in}} & port_direction_reg & ~bbm_hold;
  assign pad_out = port_output_value_reg;
  assign pad_pullup_out = {WIDTH{rstn_in & ~global_pullup_disable}} & pullup_enable_reg;

  // Sleep sequencing, wake state drives the flag catch
  assign next_sleep_state = (sleep_state == GDIO_SLP_AWAKE) ? (sleep_request ? GDIO_SLP_DEEP : GDIO_SLP_AWAKE) :
                            (sleep_state == GDIO_SLP_DEEP) ? (sleep_request ? GDIO_SLP_DEEP : GDIO_SLP_WAKE) :
                            GDIO_SLP_AWAKE;
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) sleep_state <= GDIO_SLP_AWAKE;
    else sleep_state <= next_sleep_state;
  end

  assign input_clamp_out = {WIDTH{sleep_state == GDIO_SLP_DEEP}} & ~ext_int_enable & ~alt_claim_in;
  wire [WIDTH-1:0] pin_level = pad_in & ~input_clamp_out;

  // Falling-edge capture stage, the latch of the synchroniser
  always_ff @(negedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) sync_latch <= '0;
    else sync_latch <= pin_level;
  end
  // Driven level seen one period later
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) port_input_sample_reg <= '0;
    else port_input_sample_reg <= sync_latch;
  end

  // Flag on wake for high disabled pins; set wins over write-one clear
  wire [WIDTH-1:0] flag_set = {WIDTH{sleep_state == GDIO_SLP_WAKE}} & ~ext_int_enable & pad_in;
  wire [WIDTH-1:0] flag_clr = {WIDTH{wr_phase & hit_efl}} & wdata;
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) ext_int_flag <= '0;
    else ext_int_flag <= (ext_int_flag & ~flag_clr) | flag_set;
  end

  a_toggle_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (wr_phase & hit_input) |=> port_output_value_reg == ($past(port_output_value_reg) ^ $past(wdata)))
    else $error("toggle write wrong");
  // Two steps: a rising direction bit, then one dark cycle before the driver
  sequence s_bbm_rise;
    break_before_make_enable && $rose(port_direction_reg[0]);
  endsequence
  sequence s_bbm_gap_then_drive;
    !pad_oe_out[0] ##1 (pad_oe_out[0] || !port_direction_reg[0]);
  endsequence
  a_bbm_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_bbm_rise |-> s_bbm_gap_then_drive)
    else $error("break hold wrong");
  a_no_bbm: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (!break_before_make_enable & port_direction_reg[0]) |-> pad_oe_out[0])
    else $error("driver off without break mode");
  a_out_to_in: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $fell(port_direction_reg[0]) |-> !pad_oe_out[0])
    else $error("driver stays on");
  a_pud_off: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    global_pullup_disable |-> pad_pullup_out == '0)
    else $error("pullup on under disable");
  a_input_hiz: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !port_direction_reg[0] |-> !pad_oe_out[0])
    else $error("input pin driven");
  a_sync_delay: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ##2 port_input_sample_reg == $past(sync_latch))
    else $error("sync path wrong");
  a_clamp_int: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (ext_int_enable[0] | alt_claim_in[0]) |-> !input_clamp_out[0])
    else $error("enabled pin clamped");
  a_wake_flag: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (sleep_state == GDIO_SLP_WAKE && !ext_int_enable[0] && pad_in[0]) |=> ext_int_flag[0])
    else $error("wake flag missing");
  a_deep_clamp: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (sleep_request & !ext_int_enable[0] & !alt_claim_in[0]) |-> ##1 input_clamp_out[0] || !sleep_request)
    else $error("clamp missing");

  // Drivers off while reset is held, clock or not
  a_reset_tristate: assert property (@(posedge core_clk_in)
    !rstn_in |-> pad_oe_out == '0)
    else $error("pin driven in reset");

  // Pull-ups off while reset is held
  a_reset_nopull: assert property (@(posedge core_clk_in)
    !rstn_in |-> pad_pullup_out == '0)
    else $error("pullup on in reset");

  a_dir_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (wr_phase & hit_dir) |=> port_direction_reg == $past(wdata))
    else $error("direction write lost");

  a_toggle_dir: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (wr_phase & hit_input) |=> $stable(port_direction_reg))
    else $error("toggle moved direction");

  // Pull-up follows its enable when not globally disabled
  a_pullup_follow: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !global_pullup_disable |-> pad_pullup_out == pullup_enable_reg)
    else $error("pullup not following enable");

  // The dark cycle never lasts two cycles
  a_bbm_one_cycle: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    bbm_hold[0] |=> !bbm_hold[0])
    else $error("break hold too long");

  a_awake_noclamp: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (sleep_state != GDIO_SLP_DEEP) |-> input_clamp_out == '0)
    else $error("clamp while awake");

  // Write-one clears a flag when no set competes
  a_flag_clear: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (flag_clr[0] & !flag_set[0]) |=> !ext_int_flag[0])
    else $error("flag not cleared");

  // Unmapped access answers with an error
  a_unmapped_err: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (psel_in & penable_in & !hit_any) |-> pslverr_out)
    else $error("unmapped access without error");
endmodule

// ### sim/gdio_pad_model.sv
// Model of the circuitry on the pads: external drivers, pull-ups and floating pins
`timescale 1ns/1ps
module gdio_pad_model (
  // Clock for the floating pattern
  input wire logic clk_in,
  // Port side
  input wire logic [7:0] pad_out_in,
  input wire logic [7:0] pad_oe_in,
  input wire logic [7:0] pad_pullup_in,
  // Board drivers
  input wire logic [7:0] ext_en_in,
  input wire logic [7:0] ext_val_in,
  output logic [7:0] level_out
);
  logic [7:0] float_q = 8'h55;
  // Undriven pins wander so a stale level never passes for a real one
  always @(posedge clk_in) begin
    float_q <= ~float_q;
  end
  for (genvar i = 0; i < 8; i++) begin : g_pin
    assign level_out[i] = pad_oe_in[i] ? pad_out_in[i] : ext_en_in[i] ? ext_val_in[i] :
                          pad_pullup_in[i] ? 1'b1 : float_q[i];
  end
endmodule

// ### sim/general_digital_io_port_tb.sv
// Self-checking bench for the digital I/O port
`timescale 1ns/1ps
`include "gdio_params.svh"
module general_digital_io_port_tb;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic [7:0] lvl, pout, poe, ppu, clamp, alt = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  gdio_port #(.WIDTH(8)) uut (.core_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .pad_in(lvl), .pad_out(pout), .pad_oe_out(poe), .pad_pullup_out(ppu),
    .alt_claim_in(alt), .input_clamp_out(clamp));
  gdio_pad_model pads (.clk_in(clk), .pad_out_in(pout), .pad_oe_in(poe), .pad_pullup_in(ppu),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
  always #4 clk = ~clk;
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  initial begin
    #1 chk("oe_in_reset", 32'h0, {24'h0, poe});
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rdc("dir_rst", `GDIO_OFF_DIR, 32'h0);
    rdc("out_rst", `GDIO_OFF_OUT, 32'h0);
    rdc("pu_rst", `GDIO_OFF_PULLUP, 32'h0);
    rdc("bbm_rst", `GDIO_OFF_PORT_CONTROL_REG, 32'h0);
    apb(1'b1, `GDIO_OFF_OUT, 32'h0000_01a6);
    apb(1'b1, `GDIO_OFF_DIR, 32'h0000_000f);
    #1 chk("oe_dir", 32'h0f, {24'h0, poe});
    chk("pad_val", 32'ha6, {24'h0, pout});
    rdc("out_rw", `GDIO_OFF_OUT, 32'ha6);
    apb(1'b1, `GDIO_OFF_INPUT, 32'h0000_00f0);
    rdc("toggle", `GDIO_OFF_OUT, 32'h56);
    apb(1'b1, `GDIO_OFF_DIR, 32'h0000_00ff);
    // Idle cycle before reading back a driven level
    @(posedge clk);
    rdc("readback", `GDIO_OFF_INPUT, 32'h56);
    apb(1'b1, `GDIO_OFF_PULLUP, 32'h0000_00a5);
    #1 chk("pu_on", 32'ha5, {24'h0, ppu});
    apb(1'b1, `GDIO_OFF_MCU_CONTROL_REG, 32'h1);
    #1 chk("pu_global_off", 32'h0, {24'h0, ppu});
    apb(1'b1, `GDIO_OFF_DIR, 32'h0);
    #1 chk("no_tristate_gap", 32'h0, {24'h0, poe});
    apb(1'b1, `GDIO_OFF_PORT_CONTROL_REG, 32'h1);
    // Direction changes stay at least two cycles apart
    apb(1'b1, `GDIO_OFF_DIR, 32'h0000_00ff);
    #1 chk("bbm_gap", 32'h0, {24'h0, poe});
    @(posedge clk);
    #1 chk("bbm_drive", 32'hff, {24'h0, poe});
    apb(1'b1, `GDIO_OFF_DIR, 32'h0);
    ext_en <= 8'hff;
    ext_val <= 8'h81;
    repeat (3) @(posedge clk);
    rdc("ext_sample", `GDIO_OFF_INPUT, 32'h81);
    rdc("bad_addr", 12'h100, 32'h0);
    chk("bad_err", 32'h1, {31'h0, err});
    apb(1'b1, `GDIO_OFF_EXTINT, 32'h1);
    alt <= 8'h02;
    apb(1'b1, `GDIO_OFF_SLEEP, 32'h1);
    @(posedge clk);
    #1 chk("clamp", 32'hfc, {24'h0, clamp});
    apb(1'b1, `GDIO_OFF_SLEEP, 32'h0);
    @(posedge clk);
    rdc("wake_flag", `GDIO_OFF_EXTFLAG, 32'h80);
    apb(1'b1, `GDIO_OFF_EXTFLAG, 32'h0000_0080);
    rdc("flag_clear", `GDIO_OFF_EXTFLAG, 32'h0);
    apb(1'b1, `GDIO_OFF_PULLUP, 32'h0000_00ff);
    apb(1'b1, `GDIO_OFF_MCU_CONTROL_REG, 32'h0);
    #2 rstn = 1'b0;
    #1 chk("rst_oe", 32'h0, {24'h0, poe});
    chk("rst_pu", 32'h0, {24'h0, ppu});
    @(posedge clk);
    rstn <= 1'b1;
    rdc("dir_rst2", `GDIO_OFF_DIR, 32'h0);
    rdc("pu_rst2", `GDIO_OFF_PULLUP, 32'h0);
    end_of_test();
  end
endmodule
